// ### sac_pkg.sv
// Functional notes
// - writing 1 to start bit 7 of primary control begins a conversion.
// - start bit clears itself once conversion begins; reads return zero.
// - mode 00 disabled, 01 software start, 11 repeat, 10 reserved.
// - input control bit 0 enables analog inputs, 1 disables them.
// - channel codes 0000 to 0101 pick channels 0 to 5; others reserved.
// - low-power entry resets both control registers and blocks writes.
// - ladder bit 5: 0 connects ladder during conversion, 1 always.
// - time codes 000,010..110 give 39..1248 cycles; 001, 111 reserved.
// - top two bits of timing register read undefined (here zero).
// - result bits 9..2 go to high register, bits 1..0 to low bits 7..6.
// - completion stores result, sets end flag and pulses done interrupt together.
// - reading high result register clears the end flag.
// - busy set at start, cleared at finish and on stop or slow entry.
// - low register bits 3..0 unstable (here zero); result registers read-only.
// - software mode converts the selected channel exactly once per start.
// - repeat mode restarts automatically after each completion.
// - writing mode 00 aborts at once; partial result is not stored.
// - a new start clears the end flag; old result stays until completion.
package sac_pkg;
	localparam logic [7:0] OFS_CTRL_PRI = 8'h0e;
	localparam logic [7:0] OFS_CTRL_TIM = 8'h0f;
	localparam logic [7:0] OFS_RES_LOW = 8'h20;
	localparam logic [7:0] OFS_RES_HIGH = 8'h21;
	localparam logic [7:0] RST_CTRL_PRI = 8'h10;
	localparam logic [7:0] RST_CTRL_TIM = 8'h10;
	localparam int START_BIT = 7;
	localparam int LADDER_BIT = 5;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_SOFT = 2'h1;
	localparam logic [1:0] MODE_REPEAT = 2'h3;
	localparam logic [3:0] CHAN_MAX = 4'h5;
	localparam int RES_W = 10;
	localparam logic [10:0] CYC_39 = 11'd39;
	localparam logic [10:0] CYC_78 = 11'd78;
	localparam logic [10:0] CYC_156 = 11'd156;
	localparam logic [10:0] CYC_312 = 11'd312;
	localparam logic [10:0] CYC_624 = 11'd624;
	localparam logic [10:0] CYC_1248 = 11'd1248;

	typedef struct packed {
		logic start;
		logic [1:0] mode;
		logic in_dis;
		logic [3:0] chan;
	} sac_pri_t;

	typedef struct packed {
		logic ladder_on;
		logic [2:0] tsel;
	} sac_tim_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_CONV = 2'b10
	} sac_state_t;
endpackage : sac_pkg

// ### sac_adc_ctrl.sv
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/100ps
module sac_adc_ctrl (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// avalon-mm slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// power mode
	input wire logic low_power,
	input wire logic stop_slow,
	// analog side
	input wire logic comparator_in,
	output logic [9:0] dac_code,
	output logic [3:0] chan_sel,
	output logic sample_hold,
	output logic ladder_connect,
	output logic analog_input_disable,
	output logic conversion_done_interrupt
);
	////////////////////////////////////////////////////////////////
	// synchronisers for asynchronous pins
	logic [1:0] lp_sync_r, ss_sync_r, cmp_sync_r;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			lp_sync_r <= 2'h0;
			ss_sync_r <= 2'h0;
			cmp_sync_r <= 2'h0;
		end else begin
			lp_sync_r <= {lp_sync_r[0], low_power};
			ss_sync_r <= {ss_sync_r[0], stop_slow};
			cmp_sync_r <= {cmp_sync_r[0], comparator_in};
		end
	end
	logic lp, ss, cmp;
	assign lp = lp_sync_r[1] | ss_sync_r[1];
	assign ss = ss_sync_r[1];
	assign cmp = cmp_sync_r[1];

	////////////////////////////////////////////////////////////////
	// register and sequencer state
	sac_pkg::sac_pri_t pri_r, pri_nxt;
	sac_pkg::sac_tim_t tim_r, tim_nxt;
	sac_pkg::sac_state_t st_r, st_nxt;
	logic [10:0] cnt_r, cnt_nxt, dur_r, dur_nxt;
	logic [9:0] sar_r, sar_nxt, res_r, res_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic eoc_r, eoc_nxt, irq_r, irq_nxt, ack_r, ack_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic [10:0] dur_sel;
	logic wr_pri, wr_tim, go, step, last_bit;

	// decode conversion time; reserved codes fall back to the shortest
	always_comb begin
		unique case (tim_r.tsel)
			3'h2: dur_sel = sac_pkg::CYC_78;
			3'h3: dur_sel = sac_pkg::CYC_156;
			3'h4: dur_sel = sac_pkg::CYC_312;
			3'h5: dur_sel = sac_pkg::CYC_624;
			3'h6: dur_sel = sac_pkg::CYC_1248;
			default: dur_sel = sac_pkg::CYC_39;
		endcase
	end

	// writes are blocked while low power holds the registers at reset value
	assign wr_pri = avs_write && !ack_r && !lp && avs_address == sac_pkg::OFS_CTRL_PRI;
	assign wr_tim = avs_write && !ack_r && !lp && avs_address == sac_pkg::OFS_CTRL_TIM;
	// start only counts in a valid mode; reserved mode 10 ignores it
	assign go = wr_pri && avs_writedata[sac_pkg::START_BIT] &&
		(avs_writedata[6:5] == sac_pkg::MODE_SOFT ||
		avs_writedata[6:5] == sac_pkg::MODE_REPEAT);
	// a bit decision every dur/10 cycles, last one lands on the full count
	assign step = (cnt_r == dur_r - 11'd1) ||
		((cnt_r + 11'd1) % (dur_r / 11'd10) == 11'd0 && bit_r != 4'd0);
	assign last_bit = (bit_r == 4'd0);

	// control registers
	always_comb begin
		pri_nxt = pri_r;
		tim_nxt = tim_r;
		if (lp) begin
			pri_nxt = sac_pkg::sac_pri_t'(sac_pkg::RST_CTRL_PRI);
			tim_nxt = '0;
		end else begin
			if (wr_pri) begin
				pri_nxt = sac_pkg::sac_pri_t'(avs_writedata[7:0]);
				pri_nxt.start = 1'b0; // start self-clears, never stored
			end
			if (wr_tim) begin
				tim_nxt.ladder_on = avs_writedata[sac_pkg::LADDER_BIT];
				tim_nxt.tsel = avs_writedata[3:1];
			end
		end
	end

	// sequencer: counts cycles and runs the successive approximation
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		dur_nxt = dur_r;
		sar_nxt = sar_r;
		bit_nxt = bit_r;
		res_nxt = res_r;
		eoc_nxt = eoc_r;
		irq_nxt = 1'b0;
		if (avs_read && !ack_r && avs_address == sac_pkg::OFS_RES_HIGH)
			eoc_nxt = 1'b0;
		unique case (st_r)
			sac_pkg::ST_IDLE: begin
				if (go && !lp) begin
					st_nxt = sac_pkg::ST_CONV;
					cnt_nxt = '0;
					dur_nxt = dur_sel;
					bit_nxt = 4'd9;
					sar_nxt = 10'h200; // msb trial first
					eoc_nxt = 1'b0;
				end
			end
			sac_pkg::ST_CONV: begin
				cnt_nxt = cnt_r + 11'd1;
				if (step) begin
					if (!cmp)
						sar_nxt[bit_r] = 1'b0; // input below trial
					if (!last_bit) begin
						sar_nxt[bit_r - 4'd1] = 1'b1;
						bit_nxt = bit_r - 4'd1;
					end
				end
				if (cnt_r == dur_r - 11'd1) begin
					res_nxt = sar_nxt;
					eoc_nxt = 1'b1;
					irq_nxt = 1'b1;
					if (pri_r.mode == sac_pkg::MODE_REPEAT) begin
						cnt_nxt = '0;
						dur_nxt = dur_sel;
						bit_nxt = 4'd9;
						sar_nxt = 10'h200;
					end else begin
						st_nxt = sac_pkg::ST_IDLE;
					end
				end
				// abort without storing on disable or low power
				if (pri_r.mode == sac_pkg::MODE_OFF || lp) begin
					st_nxt = sac_pkg::ST_IDLE;
					res_nxt = res_r;
					eoc_nxt = eoc_r & ~ss;
					irq_nxt = 1'b0;
				end
			end
			default: st_nxt = sac_pkg::ST_IDLE;
		endcase
		// stop/slow clears earlier results
		if (ss) begin
			res_nxt = '0;
			eoc_nxt = 1'b0;
		end
	end

	// bus: one wait cycle, then answer; unmapped reads give zero
	always_comb begin
		ack_nxt = (avs_read || avs_write) && !ack_r;
		rd_nxt = rd_r;
		if (avs_read && !ack_r) begin
			unique case (avs_address)
				sac_pkg::OFS_CTRL_PRI: rd_nxt = {24'h0, 1'b0, pri_r.mode,
					pri_r.in_dis, pri_r.chan};
				sac_pkg::OFS_CTRL_TIM: rd_nxt = {24'h0, 2'b00, tim_r.ladder_on,
					1'b1, tim_r.tsel, 1'b0};
				sac_pkg::OFS_RES_LOW: rd_nxt = {24'h0, res_r[1:0], eoc_r,
					st_r == sac_pkg::ST_CONV, 4'h0};
				sac_pkg::OFS_RES_HIGH: rd_nxt = {24'h0, res_r[9:2]};
				default: rd_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pri_r <= sac_pkg::sac_pri_t'(sac_pkg::RST_CTRL_PRI);
			tim_r <= '0;
			st_r <= sac_pkg::ST_IDLE;
			cnt_r <= '0;
			dur_r <= sac_pkg::CYC_39;
			sar_r <= '0;
			bit_r <= '0;
			res_r <= '0;
			eoc_r <= 1'b0;
			irq_r <= 1'b0;
			ack_r <= 1'b0;
			rd_r <= '0;
		end else begin
			pri_r <= pri_nxt;
			tim_r <= tim_nxt;
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			dur_r <= dur_nxt;
			sar_r <= sar_nxt;
			bit_r <= bit_nxt;
			res_r <= res_nxt;
			eoc_r <= eoc_nxt;
			irq_r <= irq_nxt;
			ack_r <= ack_nxt;
			rd_r <= rd_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// analog-side outputs registered from state
	logic busy_nxt;
	assign busy_nxt = (st_nxt == sac_pkg::ST_CONV);
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dac_code <= '0;
			chan_sel <= '0;
			sample_hold <= 1'b0;
			ladder_connect <= 1'b0;
			analog_input_disable <= 1'b1;
		end else begin
			dac_code <= sar_nxt;
			chan_sel <= (pri_nxt.chan > sac_pkg::CHAN_MAX) ? 4'h0 : pri_nxt.chan;
			sample_hold <= busy_nxt && cnt_nxt == 11'd0;
			ladder_connect <= tim_nxt.ladder_on | busy_nxt;
			analog_input_disable <= pri_nxt.in_dis;
		end
	end
	assign avs_readdata = rd_r;
	assign avs_waitrequest = !ack_r;
	assign conversion_done_interrupt = irq_r;

	////////////////////////////////////////////////////////////////
	// checks
	start_clears_a: assert property (@(posedge mclk) disable iff (!rstn)
		go && !lp |=> st_r == sac_pkg::ST_CONV && !pri_r.start && !eoc_r)
		else $error("start did not begin conversion");
	done_flags_a: assert property (@(posedge mclk) disable iff (!rstn)
		irq_r |-> eoc_r || $past(ss))
		else $error("interrupt without end flag");
	high_read_a: assert property (@(posedge mclk) disable iff (!rstn)
		avs_read && !ack_r && avs_address == sac_pkg::OFS_RES_HIGH && !irq_nxt |=> !eoc_r)
		else $error("end flag not cleared by high read");
	abort_keep_a: assert property (@(posedge mclk) disable iff (!rstn)
		st_r == sac_pkg::ST_CONV && pri_r.mode == sac_pkg::MODE_OFF && !ss
		|=> st_r == sac_pkg::ST_IDLE && $stable(res_r))
		else $error("abort stored a partial result");
	lp_init_a: assert property (@(posedge mclk) disable iff (!rstn)
		lp |=> pri_r == sac_pkg::sac_pri_t'(sac_pkg::RST_CTRL_PRI)
		&& st_r == sac_pkg::ST_IDLE)
		else $error("low power did not initialise");
	repeat_go_a: assert property (@(posedge mclk) disable iff (!rstn)
		irq_nxt && pri_r.mode == sac_pkg::MODE_REPEAT && !lp |=> st_r == sac_pkg::ST_CONV)
		else $error("repeat did not restart");
	soft_once_a: assert property (@(posedge mclk) disable iff (!rstn)
		irq_nxt && pri_r.mode == sac_pkg::MODE_SOFT |=> st_r == sac_pkg::ST_IDLE)
		else $error("software mode converted twice");
	dur_min_a: assert property (@(posedge mclk) disable iff (!rstn)
		irq_r |-> dur_r >= sac_pkg::CYC_39 && $past(cnt_r) == dur_r - 11'd1)
		else $error("conversion length wrong");
	// ladder output is registered from next state, so it lines up with st_r
	ladder_a: assert property (@(posedge mclk) disable iff (!rstn)
		st_r == sac_pkg::ST_CONV |-> ladder_connect)
		else $error("ladder open during conversion");
	bus_ans_a: assert property (@(posedge mclk) disable iff (!rstn)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");

	////////////////////////////////////////////////////////////////
	// register read-back checks
	// waitrequest drops for exactly one cycle per transfer
	wait_one_a: assert property (@(posedge mclk) disable iff (!rstn)
		!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	// registers are eight bits wide, the upper bus lanes stay quiet
	upper_zero_a: assert property (@(posedge mclk) disable iff (!rstn)
		!avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
		else $error("upper read lanes not zero");
	// the start bit is never read back as one
	start_read_a: assert property (@(posedge mclk) disable iff (!rstn)
		avs_read && !ack_r && avs_address == sac_pkg::OFS_CTRL_PRI |=> !avs_readdata[7])
		else $error("start bit read back set");
	// fixed bits of the timing register read as their required values
	tim_read_a: assert property (@(posedge mclk) disable iff (!rstn)
		avs_read && !ack_r && avs_address == sac_pkg::OFS_CTRL_TIM
		|=> avs_readdata[7:6] == 2'h0 && avs_readdata[4] && !avs_readdata[0])
		else $error("timing register fixed bits wrong");
	// unstable low bits of the status register are given as zero
	low_read_a: assert property (@(posedge mclk) disable iff (!rstn)
		avs_read && !ack_r && avs_address == sac_pkg::OFS_RES_LOW
		|=> avs_readdata[3:0] == 4'h0)
		else $error("status low bits not zero");
	// busy bit reports the sequencer state at the edge the read was taken
	busy_flag_a: assert property (@(posedge mclk) disable iff (!rstn)
		avs_read && !ack_r && avs_address == sac_pkg::OFS_RES_LOW
		|=> avs_readdata[4] == $past(st_r == sac_pkg::ST_CONV))
		else $error("busy bit wrong");

	////////////////////////////////////////////////////////////////
	// analog-side and sequencer checks
	// reserved channel codes never reach the multiplexer
	chan_legal_a: assert property (@(posedge mclk) disable iff (!rstn)
		chan_sel <= sac_pkg::CHAN_MAX)
		else $error("reserved channel selected");
	// input disable follows the control bit
	aind_a: assert property (@(posedge mclk) disable iff (!rstn)
		analog_input_disable == pri_r.in_dis)
		else $error("input disable not following control");
	// with the ladder bit clear, the ladder is open while idle
	ladder_idle_a: assert property (@(posedge mclk) disable iff (!rstn)
		st_r == sac_pkg::ST_IDLE && !tim_r.ladder_on |-> !ladder_connect)
		else $error("ladder connected while idle");
	// sample pulse is one cycle long
	sh_pulse_a: assert property (@(posedge mclk) disable iff (!rstn)
		sample_hold |=> !sample_hold)
		else $error("sample pulse too long");
	// every conversion opens with the msb trial
	sh_msb_a: assert property (@(posedge mclk) disable iff (!rstn)
		sample_hold |-> dac_code == 10'h200 && st_r == sac_pkg::ST_CONV)
		else $error("first trial not msb");
	// completion interrupt is a single-cycle pulse
	irq_pulse_a: assert property (@(posedge mclk) disable iff (!rstn)
		irq_r |=> !irq_r)
		else $error("interrupt pulse too long");
	// the result moves only at completion or when stop/slow clears it
	res_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
		$changed(res_r) |-> irq_r || $past(ss))
		else $error("result changed outside completion");
	// stop/slow wipes earlier results and the end flag
	ss_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
		ss |=> !eoc_r && res_r == 10'h000)
		else $error("stop entry kept result");
	// timing register stays at its initial value in low power
	tim_block_a: assert property (@(posedge mclk) disable iff (!rstn)
		lp |=> tim_r == '0)
		else $error("timing register written in low power");
	conv_c: cover property (@(posedge mclk) disable iff (!rstn) irq_r);
	rep_c: cover property (@(posedge mclk) disable iff (!rstn)
		irq_r && pri_r.mode == sac_pkg::MODE_REPEAT);
	abort_c: cover property (@(posedge mclk) disable iff (!rstn)
		st_r == sac_pkg::ST_CONV && pri_r.mode == sac_pkg::MODE_OFF);
	long_c: cover property (@(posedge mclk) disable iff (!rstn)
		irq_r && tim_r.tsel == 3'h6);
	stop_c: cover property (@(posedge mclk) disable iff (!rstn)
		ss && st_r == sac_pkg::ST_CONV);
endmodule : sac_adc_ctrl

// ### sac_analog_model.sv
`timescale 1ns/100ps
module sac_analog_model (
	// trial code and channel from the block
	input wire logic [9:0] dac_code,
	input wire logic [3:0] chan_sel,
	// input level chosen by the bench
	input wire logic [9:0] vin_base,
	// comparator answer
	output logic comparator_in
);
	// each channel sees a slightly different level, so a wrong channel gives a wrong result
	// answers at once; the block's own synchroniser adds the settling delay
	assign comparator_in = ((vin_base ^ {6'h00, chan_sel}) >= dac_code);
endmodule : sac_analog_model

// ### testbench.sv
`timescale 1ns/100ps
module testbench;
	logic mclk, rstn, avs_read, avs_write, low_power, stop_slow, comparator_in;
	logic avs_waitrequest, sample_hold, ladder_connect, analog_input_disable, done_irq;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [9:0] dac_code, vin_base, lv;
	logic [3:0] chan_sel;
	int fails = 0;
	int checked = 0;
	int cyc = 0;
	int irq_cyc = 0;
	int irq_cnt = 0;

	sac_adc_ctrl uut (.mclk(mclk), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.low_power(low_power), .stop_slow(stop_slow), .comparator_in(comparator_in),
		.dac_code(dac_code), .chan_sel(chan_sel), .sample_hold(sample_hold),
		.ladder_connect(ladder_connect), .analog_input_disable(analog_input_disable),
		.conversion_done_interrupt(done_irq));
	sac_analog_model model (.dac_code(dac_code), .chan_sel(chan_sel), .vin_base(vin_base),
		.comparator_in(comparator_in));

	////////////////////////////////////////////////////////////////////////////////
	// clock, cycle count and completion pulse monitor
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (done_irq === 1'b1) begin
			irq_cnt <= irq_cnt + 1;
			irq_cyc <= cyc;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// one avalon transfer; request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_read <= ~wr;
		avs_write <= wr;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 200);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 200) check(32'h1, 32'h0);
	endtask : bus
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		check(rd, {24'h000000, exp});
	endtask : rd_chk
	// bounded wait for the next completion pulse
	task automatic wait_irq(input int prev);
		int n;
		n = 0;
		while (irq_cnt == prev && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		check(32'(irq_cnt != prev), 32'h1);
	endtask : wait_irq

	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		check(32'(analog_input_disable), 32'h1);
		rd_chk(sac_pkg::OFS_CTRL_PRI, sac_pkg::RST_CTRL_PRI);
		rd_chk(sac_pkg::OFS_CTRL_TIM, sac_pkg::RST_CTRL_TIM);
		rd_chk(sac_pkg::OFS_RES_HIGH, 8'h00);
		rd_chk(8'h33, 8'h00);
	endtask : t_reset
	task automatic t_single();
		int prev;
		vin_base = 10'h2b2;
		lv = 10'h2b2 ^ 10'h005;
		prev = irq_cnt;
		bus(1'b1, sac_pkg::OFS_CTRL_TIM, 8'h10);
		bus(1'b1, sac_pkg::OFS_CTRL_PRI, 8'ha5);
		rd_chk(sac_pkg::OFS_CTRL_PRI, 8'h25);
		rd_chk(sac_pkg::OFS_RES_LOW, 8'h10);
		check({28'h0, chan_sel}, 32'h5);
		check({30'h0, analog_input_disable, ladder_connect}, 32'h1);
		wait_irq(prev);
		rd_chk(sac_pkg::OFS_RES_LOW, {lv[1:0], 6'h20});
		rd_chk(sac_pkg::OFS_RES_HIGH, lv[9:2]);
		bus(1'b1, sac_pkg::OFS_RES_HIGH, 8'hff);
		rd_chk(sac_pkg::OFS_RES_LOW, {lv[1:0], 6'h00});
		repeat (60) @(posedge mclk);
		check(32'(irq_cnt - prev), 32'h1);
		check(32'(ladder_connect), 32'h0);
	endtask : t_single
	// every time code except reserved 001, ladder held on; reserved 111 runs the shortest time
	task automatic t_times();
		int durs [7] = '{39, 78, 156, 312, 624, 1248, 39};
		logic [2:0] codes [7] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
		int prev, t0, d;
		for (int i = 0; i < 7; i++) begin
			bus(1'b1, sac_pkg::OFS_CTRL_TIM, {4'h3, codes[i], 1'b0});
			check(32'(ladder_connect), 32'h1);
			prev = irq_cnt;
			bus(1'b1, sac_pkg::OFS_CTRL_PRI, 8'ha0);
			t0 = cyc;
			wait_irq(prev);
			d = irq_cyc - t0;
			check(32'(d >= durs[i] - 4 && d <= durs[i] + 4), 32'h1);
			bus(1'b0, sac_pkg::OFS_RES_HIGH, 8'h00);
		end
	endtask : t_times
	task automatic t_repeat();
		int prev;
		vin_base = 10'h13c;
		lv = 10'h13c ^ 10'h003;
		bus(1'b1, sac_pkg::OFS_CTRL_TIM, 8'h18);
		prev = irq_cnt;
		bus(1'b1, sac_pkg::OFS_CTRL_PRI, 8'he3);
		wait_irq(prev);
		wait_irq(prev + 1);
		vin_base = 10'h0f0;
		rd_chk(sac_pkg::OFS_RES_LOW, {lv[1:0], 6'h30});
		bus(1'b1, sac_pkg::OFS_CTRL_PRI, 8'h03);
		rd_chk(sac_pkg::OFS_RES_HIGH, lv[9:2]);
		rd_chk(sac_pkg::OFS_RES_LOW, {lv[1:0], 6'h00});
		prev = irq_cnt;
		repeat (400) @(posedge mclk);
		check(32'(irq_cnt), 32'(prev));
	endtask : t_repeat
	task automatic t_power();
		bus(1'b1, sac_pkg::OFS_CTRL_TIM, 8'h1a);
		bus(1'b1, sac_pkg::OFS_CTRL_PRI, 8'ha5);
		stop_slow <= 1'b1;
		repeat (6) @(posedge mclk);
		rd_chk(sac_pkg::OFS_RES_LOW, 8'h00);
		rd_chk(sac_pkg::OFS_CTRL_PRI, sac_pkg::RST_CTRL_PRI);
		stop_slow <= 1'b0;
		low_power <= 1'b1;
		repeat (6) @(posedge mclk);
		bus(1'b1, sac_pkg::OFS_CTRL_PRI, 8'h05);
		rd_chk(sac_pkg::OFS_CTRL_PRI, sac_pkg::RST_CTRL_PRI);
		bus(1'b1, sac_pkg::OFS_CTRL_TIM, 8'h3c);
		rd_chk(sac_pkg::OFS_CTRL_TIM, sac_pkg::RST_CTRL_TIM);
	endtask : t_power

	////////////////////////////////////////////////////////////////////////////////
	// verdict, main sequence and watchdog
	task automatic tally_and_finish();
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		rstn = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 8'h00;
		avs_writedata = 32'h00000000;
		low_power = 1'b0;
		stop_slow = 1'b0;
		vin_base = 10'h000;
		repeat (8) @(posedge mclk);
		rstn <= 1'b1;
		t_reset();
		t_single();
		t_times();
		t_repeat();
		t_power();
		tally_and_finish();
	end
	// the tests need about 4000 cycles; a hang is cut well beyond that
	initial begin
		repeat (40000) @(posedge mclk);
		fails++;
		tally_and_finish();
	end
endmodule : testbench
